// ===== src/fdc_ctrl_end.sv
// controller end: host registers, phase sequencer, result stack, seeks
// assumes one clock; drive pins arrive asynchronous and are synchronised
`timescale 1ns/10ps
`default_nettype none
module fdc_ctrl_end #(
	parameter int unsigned STEP_CYCLES = fdc_pkg::STEP_CYCLES
) (
	input wire logic clk_i,
	input wire logic rst_n_i,
	fdc_bus_if.device bus,
	input wire logic media_changed_pin_n_i,
	input wire logic track_zero_pin_n_i,
	input wire logic drive_fault_i,
	input wire logic write_protect_i,
	input wire logic drive_ready_i,
	input wire logic two_sided_i,
	input wire logic dma_req_i,
	input wire logic [7:0] st1_events_i,
	input wire logic [7:0] st2_events_i,
	output logic drive_choice_o,
	output logic [1:0] motor_en_o,
	output logic side_select_o,
	output logic step_o,
	output logic step_dir_o,
	output logic [1:0] rate_sel_o,
	output logic reduce_write_o,
	output logic core_reset_o
);
	localparam logic [15:0] STEP_LOAD = 16'(STEP_CYCLES - 1);

	typedef struct packed {
		logic [5:0] sync1;
		logic [5:0] sync2;
		logic [1:0] motor;
		logic gate;
		logic dor_nreset;
		logic drive;
		logic [1:0] rate;
		logic rate_reset;
		logic non_dma;
		fdc_pkg::phase_t phase;
		logic host_transfer_request;
		logic [3:0] cmd_cnt;
		logic [3:0] cmd_len;
		logic [8:0][7:0] cmd_buf;
		logic [6:0][7:0] res_buf;
		logic [2:0] res_cnt;
		logic [2:0] res_idx;
		logic irq_pend;
		logic [7:0] int_st0;
		logic [1:0] seeking;
		logic [1:0][7:0] pcn;
		logic unit;
		logic head;
		logic recal;
		logic [7:0] target;
		logic [6:0] steps_left;
		logic [15:0] step_cnt;
		logic step;
		logic dir;
		logic [7:0] st1;
		logic [7:0] st2;
		logic [7:0] rdata;
		logic [7:0] rdata_oe;
	} ctrl_t;

	ctrl_t s, next_s;
	logic core_rst, data_wr, data_rd, done, ec;
	logic [7:0] main_handshake_status, cur, st3, st0;
	logic [3:0] len;

	// bytes per command, opcode in low five bits
	function automatic logic [3:0] cmd_bytes(input logic [7:0] op);
		case (op[4:0])
			fdc_pkg::OP_SPECIFY: cmd_bytes = 4'h3;
			fdc_pkg::OP_SEEK: cmd_bytes = 4'h3;
			fdc_pkg::OP_SENSE_DRIVE: cmd_bytes = 4'h2;
			fdc_pkg::OP_RECALIBRATE: cmd_bytes = 4'h2;
			fdc_pkg::OP_READ_ID: cmd_bytes = 4'h2;
			default: cmd_bytes = 4'h1;
		endcase
	endfunction

	// status views built from registered state only
	always_comb begin
		core_rst = !s.dor_nreset || s.rate_reset;
		main_handshake_status = {s.host_transfer_request, s.phase == fdc_pkg::P_RESULT, s.non_dma,
			s.cmd_cnt != 4'h0 || s.phase != fdc_pkg::P_CMD,
			2'h0, s.seeking};
		st3 = {s.sync2[2], s.sync2[3], s.sync2[4], !s.sync2[1],
			s.sync2[5], s.head, 1'b0, s.drive};
		cur = s.pcn[s.unit];
		data_wr = bus.wr && bus.addr == fdc_pkg::COMMAND_DATA_STACK &&
			s.host_transfer_request && s.phase == fdc_pkg::P_CMD;
		data_rd = bus.rd && bus.addr == fdc_pkg::COMMAND_DATA_STACK &&
			s.host_transfer_request && s.phase == fdc_pkg::P_RESULT;
		len = (s.cmd_cnt == 4'h0) ? cmd_bytes(bus.wdata) : s.cmd_len;
	end

	// next-state: register writes, phase sequencing, stepping
	always_comb begin
		next_s = s;
		done = 1'b0;
		ec = 1'b0;
		st0 = 8'h00;
		next_s.sync1 = {two_sided_i, drive_ready_i, write_protect_i,
			drive_fault_i, track_zero_pin_n_i, media_changed_pin_n_i};
		next_s.sync2 = s.sync1;
		next_s.rate_reset = 1'b0; // self-clearing
		next_s.step = 1'b0;
		// hardware keeps setting error flags even in the clearing cycle
		next_s.st1 = s.st1 | (st1_events_i & fdc_pkg::ST1_LIVE_MASK);
		next_s.st2 = s.st2 | (st2_events_i & fdc_pkg::ST2_LIVE_MASK);
		if (bus.wr && bus.addr == fdc_pkg::DRIVE_OUTPUT_CONTROL) begin
			next_s.motor = {bus.wdata[fdc_pkg::DOC_MOTOR_B],
				bus.wdata[fdc_pkg::DOC_MOTOR_A]};
			next_s.gate = bus.wdata[fdc_pkg::DOC_IRQ_DMA_GATE];
			next_s.dor_nreset = bus.wdata[fdc_pkg::DOC_RESET_N];
			next_s.drive = bus.wdata[fdc_pkg::DOC_DRIVE_CHOICE];
		end
		if (bus.wr && bus.addr == fdc_pkg::TRANSFER_RATE_SELECT) begin
			next_s.rate = bus.wdata[1:0];
			next_s.rate_reset = bus.wdata[fdc_pkg::RATE_RESET_BIT];
		end
		case (s.phase)
			fdc_pkg::P_CMD: begin
				if (data_wr) begin
					if (s.cmd_cnt == 4'h0) begin
						next_s.cmd_len = len;
						next_s.st1 = st1_events_i & fdc_pkg::ST1_LIVE_MASK;
						next_s.st2 = st2_events_i & fdc_pkg::ST2_LIVE_MASK;
					end
					next_s.cmd_buf[s.cmd_cnt] = bus.wdata;
					next_s.cmd_cnt = s.cmd_cnt + 4'h1;
					if (s.cmd_cnt + 4'h1 >= len)
						next_s.phase = fdc_pkg::P_DECODE;
				end
			end
			fdc_pkg::P_DECODE: begin
				next_s.cmd_cnt = 4'h0;
				next_s.res_idx = 3'h0;
				next_s.res_cnt = 3'h1;
				next_s.phase = fdc_pkg::P_RESULT;
				next_s.irq_pend = 1'b1;
				next_s.unit = s.cmd_buf[1][0];
				next_s.head = s.cmd_buf[1][2];
				next_s.res_buf[0] = fdc_pkg::INVALID_ST0;
				case (s.cmd_buf[0][4:0])
					fdc_pkg::OP_SPECIFY: begin
						next_s.non_dma = s.cmd_buf[2][0];
						next_s.irq_pend = s.irq_pend;
						next_s.phase = fdc_pkg::P_CMD;
					end
					fdc_pkg::OP_SENSE_DRIVE: begin
						next_s.res_buf[0] = {st3[7:3], s.cmd_buf[1][2],
							1'b0, s.cmd_buf[1][0]};
					end
					fdc_pkg::OP_SENSE_INT: begin
						// a poll with nothing pending is refused as invalid
						next_s.irq_pend = 1'b0;
						if (s.irq_pend) begin
							next_s.res_buf[0] = s.int_st0;
							next_s.res_buf[1] = s.pcn[s.int_st0[1]];
							next_s.res_cnt = 3'h2;
						end
					end
					fdc_pkg::OP_READ_ID: begin
						st0[7:6] = ((s.st1 | s.st2) != 8'h00) ?
							fdc_pkg::TERM_ABNORMAL : fdc_pkg::TERM_NORMAL;
						st0[3] = !s.sync2[4];
						st0[2] = s.cmd_buf[1][2];
						st0[1:0] = {s.cmd_buf[1][0], !s.cmd_buf[1][0]};
						next_s.res_buf = {fdc_pkg::ID_SIZE, fdc_pkg::ID_RECORD,
							7'h00, s.cmd_buf[1][2], s.pcn[s.cmd_buf[1][0]],
							s.st2, s.st1, st0};
						next_s.res_cnt = 3'h7;
					end
					fdc_pkg::OP_SEEK, fdc_pkg::OP_RECALIBRATE: begin
						next_s.irq_pend = s.irq_pend;
						next_s.recal = s.cmd_buf[0][4:0] == fdc_pkg::OP_RECALIBRATE;
						next_s.target = s.cmd_buf[0][3] ? s.cmd_buf[2] : 8'h00;
						next_s.steps_left = fdc_pkg::RECAL_STEPS;
						next_s.seeking[s.cmd_buf[1][0]] = 1'b1;
						next_s.step_cnt = STEP_LOAD;
						next_s.phase = fdc_pkg::P_EXEC;
					end
					default: ;
				endcase
			end
			fdc_pkg::P_EXEC: begin
				if (s.step_cnt != 16'h0000) begin
					next_s.step_cnt = s.step_cnt - 16'h0001;
				end else begin
					next_s.step_cnt = STEP_LOAD;
					if (s.recal && !s.sync2[1]) begin
						done = 1'b1;
						next_s.pcn[s.unit] = 8'h00;
					end else if (s.recal && s.steps_left == 7'h00) begin
						done = 1'b1; // track zero never seen
						ec = 1'b1;
					end else if (!s.recal && cur == s.target) begin
						done = 1'b1;
					end else begin
						next_s.step = 1'b1;
						next_s.dir = !s.recal && s.target > cur;
						next_s.steps_left = s.steps_left - 7'h01;
						next_s.pcn[s.unit] = (!s.recal && s.target > cur) ?
							cur + 8'h01 : cur - 8'h01;
					end
				end
				if (done) begin
					next_s.seeking[s.unit] = 1'b0;
					next_s.int_st0 = {ec ? fdc_pkg::TERM_ABNORMAL :
						fdc_pkg::TERM_NORMAL, 1'b1, ec, 1'b0, s.head,
						s.unit, !s.unit};
					next_s.irq_pend = 1'b1;
					next_s.phase = fdc_pkg::P_CMD;
				end
			end
			fdc_pkg::P_RESULT: begin
				if (data_rd) begin
					next_s.irq_pend = 1'b0;
					next_s.res_idx = s.res_idx + 3'h1;
					if (s.res_idx + 3'h1 >= s.res_cnt)
						next_s.phase = fdc_pkg::P_CMD;
				end
			end
			default: next_s.phase = fdc_pkg::P_CMD;
		endcase
		// read data is captured so the bus sees a flop, one cycle later
		if (bus.rd) begin
			next_s.rdata_oe = fdc_pkg::ALL_DRIVEN;
			case (bus.addr)
				fdc_pkg::DRIVE_OUTPUT_CONTROL: next_s.rdata = {2'h0, s.motor,
					s.gate, s.dor_nreset, 1'b0, s.drive};
				fdc_pkg::MAIN_HANDSHAKE_STATUS: next_s.rdata = main_handshake_status;
				fdc_pkg::COMMAND_DATA_STACK: next_s.rdata =
					data_rd ? s.res_buf[s.res_idx] : 8'h00;
				fdc_pkg::DISK_CHANGE_INPUT: begin
					next_s.rdata = {!s.sync2[0], 7'h00};
					next_s.rdata_oe = fdc_pkg::DIR_DRIVEN_MASK;
				end
				default: next_s.rdata = 8'h00;
			endcase
		end
		// core reset: idle again, output/rate/specify values kept
		if (core_rst) begin
			next_s.phase = fdc_pkg::P_CMD;
			next_s.cmd_cnt = 4'h0;
			next_s.res_idx = 3'h0;
			next_s.irq_pend = 1'b0;
			next_s.seeking = 2'h0;
			next_s.step = 1'b0;
		end
		// request drops for one cycle after each data byte, or until stepping ends after the last byte of a seek or recalibrate
		next_s.host_transfer_request = !core_rst && !data_wr && !data_rd &&
			(next_s.phase == fdc_pkg::P_CMD ||
			next_s.phase == fdc_pkg::P_RESULT);
	end

	always_ff @(posedge clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			s <= '0; // output control reset bit low holds the core
		end else begin
			s <= next_s;
		end
	end

	assign bus.rdata = s.rdata;
	assign bus.rdata_oe = s.rdata_oe;
	assign bus.irq = s.gate && s.irq_pend;
	assign bus.drq = s.gate && dma_req_i && !s.non_dma;
	assign drive_choice_o = s.drive;
	assign motor_en_o = s.motor;
	assign side_select_o = s.head;
	assign step_o = s.step;
	assign step_dir_o = s.dir;
	assign rate_sel_o = s.rate;
	assign reduce_write_o = s.rate != fdc_pkg::RATE_500K;
	assign core_reset_o = core_rst;
endmodule
`default_nettype wire

// ===== src/fdc_pkg.sv
// constants shared by both ends of the floppy controller host port
// assumes a 40 MHz controller clock and a byte-wide host i/o bus
package fdc_pkg;
	// host i/o offsets, 3-bit address
	localparam logic [2:0] DRIVE_OUTPUT_CONTROL = 3'h2;
	localparam logic [2:0] MAIN_HANDSHAKE_STATUS = 3'h4;
	localparam logic [2:0] COMMAND_DATA_STACK = 3'h5;
	localparam logic [2:0] DISK_CHANGE_INPUT = 3'h7;
	localparam logic [2:0] TRANSFER_RATE_SELECT = 3'h7;

	// drive output control fields
	localparam int DOC_MOTOR_B = 5;
	localparam int DOC_MOTOR_A = 4;
	localparam int DOC_IRQ_DMA_GATE = 3;
	localparam int DOC_RESET_N = 2;
	localparam int DOC_DRIVE_CHOICE = 0;
	// transfer rate select: self-clearing reset bit
	localparam int RATE_RESET_BIT = 7;
	localparam logic [1:0] RATE_500K = 2'h0;

	// main handshake status fields
	localparam int MSR_REQUEST = 7;
	localparam int MSR_DIRECTION = 6;

	// disk change input: only bit 7 is driven
	localparam logic [7:0] DIR_DRIVEN_MASK = 8'h80;
	localparam logic [7:0] ALL_DRIVEN = 8'hFF;

	// fixed-zero bits of the result status bytes
	localparam logic [7:0] ST1_LIVE_MASK = 8'hB7;
	localparam logic [7:0] ST2_LIVE_MASK = 8'h7F;

	// termination codes
	localparam logic [1:0] TERM_NORMAL = 2'h0;
	localparam logic [1:0] TERM_ABNORMAL = 2'h1;
	localparam logic [1:0] TERM_INVALID = 2'h2;
	localparam logic [7:0] INVALID_ST0 = 8'h80;

	// command opcodes (low five bits of the first byte)
	localparam logic [4:0] OP_SPECIFY = 5'h03;
	localparam logic [4:0] OP_SENSE_DRIVE = 5'h04;
	localparam logic [4:0] OP_RECALIBRATE = 5'h07;
	localparam logic [4:0] OP_SENSE_INT = 5'h08;
	localparam logic [4:0] OP_READ_ID = 5'h0A;
	localparam logic [4:0] OP_SEEK = 5'h0F;

	// id fields reported by the read id stand-in, and the recalibrate step limit
	localparam logic [7:0] ID_RECORD = 8'h01;
	localparam logic [7:0] ID_SIZE = 8'h02;
	localparam logic [6:0] RECAL_STEPS = 7'h4F;

	// step pulse spacing
	localparam int CLK_PERIOD_NS = 25;
	localparam int STEP_TIME_NS = 1000000;
	localparam int STEP_CYCLES = STEP_TIME_NS / CLK_PERIOD_NS;

	typedef enum logic [1:0] {
		P_CMD = 2'h0,
		P_DECODE = 2'h1,
		P_EXEC = 2'h2,
		P_RESULT = 2'h3
	} phase_t;

	typedef enum logic [1:0] {
		K_REG_WR = 2'h0,
		K_REG_RD = 2'h1,
		K_DATA_WR = 2'h2,
		K_DATA_RD = 2'h3
	} req_kind_t;
endpackage

// ===== src/fdc_bus_if.sv
// byte-wide host i/o bus between processor end and controller end
// assumes both ends share clk; strobes are one-cycle pulses
`timescale 1ns/10ps
`default_nettype none
interface fdc_bus_if;
	logic [2:0] addr;
	logic [7:0] wdata;
	logic rd;
	logic wr;
	logic [7:0] rdata;
	logic [7:0] rdata_oe;
	logic irq;
	logic drq;

	modport device (input addr, wdata, rd, wr,
		output rdata, rdata_oe, irq, drq);
	modport host (output addr, wdata, rd, wr,
		input rdata, rdata_oe, irq, drq);
endinterface
`default_nettype wire

// ===== src/fdc_host_end.sv
// processor end: turns user requests into bus cycles on the i/o port
// assumes controller registers read data one cycle after a read strobe
`timescale 1ns/10ps
`default_nettype none
module fdc_host_end (
	input wire logic clk_i,
	input wire logic rst_n_i,
	fdc_bus_if.host bus,
	input wire logic req_valid_i,
	input wire fdc_pkg::req_kind_t req_kind_i,
	input wire logic [2:0] req_addr_i,
	input wire logic [7:0] req_wdata_i,
	output logic req_ready_o,
	output logic resp_valid_o,
	output logic [7:0] resp_data_o,
	output logic irq_o
);
	typedef enum logic [2:0] {
		H_IDLE = 3'h0,
		H_POLL = 3'h1,
		H_CHECK = 3'h2,
		H_XFER = 3'h3,
		H_CAPTURE = 3'h4
	} hstate_t;

	typedef struct packed {
		hstate_t state;
		logic is_read;
		logic [2:0] addr;
		logic [7:0] wdata;
		logic rd;
		logic wr;
		logic resp_valid;
		logic [7:0] resp_data;
		logic irq;
	} host_t;

	host_t s, next_s;

	// data-stack bytes are always preceded by a status poll
	always_comb begin
		next_s = s;
		next_s.rd = 1'b0;
		next_s.wr = 1'b0;
		next_s.resp_valid = 1'b0;
		next_s.irq = bus.irq;
		case (s.state)
			H_IDLE: begin
				if (req_valid_i) begin
					next_s.wdata = req_wdata_i;
					next_s.is_read = req_kind_i == fdc_pkg::K_REG_RD ||
						req_kind_i == fdc_pkg::K_DATA_RD;
					if (req_kind_i == fdc_pkg::K_DATA_WR ||
						req_kind_i == fdc_pkg::K_DATA_RD) begin
						next_s.addr = fdc_pkg::MAIN_HANDSHAKE_STATUS;
						next_s.rd = 1'b1;
						next_s.state = H_POLL;
					end else begin
						next_s.addr = req_addr_i;
						next_s.rd = req_kind_i == fdc_pkg::K_REG_RD;
						next_s.wr = req_kind_i == fdc_pkg::K_REG_WR;
						next_s.state = H_XFER;
					end
				end
			end
			H_POLL: next_s.state = H_CHECK;
			H_CHECK: begin
				// request set and direction matching the wanted move
				if (bus.rdata[fdc_pkg::MSR_REQUEST] &&
					bus.rdata[fdc_pkg::MSR_DIRECTION] == s.is_read) begin
					next_s.addr = fdc_pkg::COMMAND_DATA_STACK;
					next_s.rd = s.is_read;
					next_s.wr = !s.is_read;
					next_s.state = H_XFER;
				end else begin
					next_s.rd = 1'b1; // keep polling
					next_s.state = H_POLL;
				end
			end
			H_XFER: begin
				next_s.state = s.is_read ? H_CAPTURE : H_IDLE;
				next_s.resp_valid = !s.is_read;
			end
			H_CAPTURE: begin
				next_s.resp_data = bus.rdata;
				next_s.resp_valid = 1'b1;
				next_s.state = H_IDLE;
			end
			default: next_s.state = H_IDLE;
		endcase
	end

	always_ff @(posedge clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			s <= '0;
		end else begin
			s <= next_s;
		end
	end

	assign bus.addr = s.addr;
	assign bus.wdata = s.wdata;
	assign bus.rd = s.rd;
	assign bus.wr = s.wr;
	assign req_ready_o = s.state == H_IDLE;
	assign resp_valid_o = s.resp_valid;
	assign resp_data_o = s.resp_data;
	assign irq_o = s.irq;
endmodule
`default_nettype wire

// ===== dv/fdc_ctrl_monitor.sv
// assertions on the byte-wide host bus between the two ends
// assumes the bus signals, one clock and an active-low async reset
`timescale 1ns/10ps
`default_nettype none
module fdc_ctrl_monitor (
	input wire logic clk_i,
	input wire logic rst_n_i,
	input wire logic [2:0] addr,
	input wire logic [7:0] wdata,
	input wire logic rd,
	input wire logic wr,
	input wire logic [7:0] rdata,
	input wire logic [7:0] rdata_oe,
	input wire logic irq,
	input wire logic drq
);
	logic [7:0] doc;

	// shadow of the drive output register, rebuilt from bus writes
	always_ff @(posedge clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			doc <= 8'h00;
		end else if (wr && addr == 3'h2) begin
			doc <= wdata;
		end
	end

	default clocking cb @(posedge clk_i); endclocking
	default disable iff (!rst_n_i);

	gate_off_a: assert property (!doc[3] |-> !irq && !drq)
		else $error("irq or drq raised while gate is off");
	doc_readback_a: assert property (rd && addr == 3'h2 |=>
		(rdata & 8'h3D) == (doc & 8'h3D))
		else $error("drive output readback differs");
	// two low cycles first: the core may clear its state one edge late
	core_hold_a: assert property (rd && addr == 3'h4 && !doc[2]
		&& !$past(doc[2]) |=> (rdata & 8'hDF) == 8'h00)
		else $error("status not idle while core held");
	rate_reset_a: assert property (wr && addr == 3'h7 && wdata[7]
		&& doc[2] ##1 (!wr throughout (##[1:8] rd && addr == 3'h4))
		|=> (rdata & 8'hDF) == 8'h80)
		else $error("rate reset did not return to idle");
	hold_rdata_a: assert property (!rd |=> $stable(rdata))
		else $error("read data moved without a read");
	oe_dir_a: assert property (rd && addr == 3'h7 |=> rdata_oe == 8'h80)
		else $error("input register drives undefined bits");
	oe_full_a: assert property (rd && addr != 3'h7 |=> rdata_oe == 8'hFF)
		else $error("register read not fully driven");
	result_busy_a: assert property (rd && addr == 3'h4 |=>
		!(rdata[7] && rdata[6]) || rdata[4])
		else $error("result phase shown without busy");

	cover property (rd && addr == 3'h5 && irq);
	cover property ($rose(drq));
	cover property (wr && addr == 3'h7 && wdata[7]);
endmodule
`default_nettype wire

// ===== dv/tb_floppy_ctrl_host_regs.sv
// self-checking bench: host end and controller end joined on one bus
// assumes both ends share the 40 MHz clock and the active-low reset
`timescale 1ns/10ps
`default_nettype none
module tb_floppy_ctrl_host_regs;
	localparam int STEPS = 16;
	logic clk_i = 1'b0;
	logic rst_n_i = 1'b0;
	logic req_valid = 1'b0;
	fdc_pkg::req_kind_t req_kind = fdc_pkg::K_REG_RD;
	logic [2:0] req_addr = 3'h0;
	logic [7:0] req_wdata = 8'h00;
	logic chg_n = 1'b1;
	logic trk0_n = 1'b1;
	logic fault = 1'b0;
	logic wp = 1'b0;
	logic rdy = 1'b1;
	logic two = 1'b0;
	logic dma_req = 1'b0;
	logic [7:0] ev1 = 8'h00;
	logic [7:0] ev2 = 8'h00;
	logic req_ready, resp_valid, irq_host, drive_choice, side_sel;
	logic step_dir, reduce_write, core_reset, step;
	int step_pulses = 0;
	logic [1:0] motor_en, rate_sel;
	logic [7:0] resp_data, q;
	int failures = 0;
	int total_checks = 0;

	fdc_bus_if bus ();
	fdc_ctrl_end #(.STEP_CYCLES(STEPS)) fdc_ctrl_end_inst (
		.clk_i(clk_i), .rst_n_i(rst_n_i), .bus(bus),
		.media_changed_pin_n_i(chg_n), .track_zero_pin_n_i(trk0_n),
		.drive_fault_i(fault), .write_protect_i(wp), .drive_ready_i(rdy),
		.two_sided_i(two), .dma_req_i(dma_req), .st1_events_i(ev1),
		.st2_events_i(ev2), .drive_choice_o(drive_choice),
		.motor_en_o(motor_en), .side_select_o(side_sel), .step_o(step),
		.step_dir_o(step_dir), .rate_sel_o(rate_sel),
		.reduce_write_o(reduce_write), .core_reset_o(core_reset));
	fdc_host_end fdc_host_end_inst (
		.clk_i(clk_i), .rst_n_i(rst_n_i), .bus(bus),
		.req_valid_i(req_valid), .req_kind_i(req_kind),
		.req_addr_i(req_addr), .req_wdata_i(req_wdata),
		.req_ready_o(req_ready), .resp_valid_o(resp_valid),
		.resp_data_o(resp_data), .irq_o(irq_host));
	fdc_ctrl_monitor fdc_ctrl_monitor_inst (
		.clk_i(clk_i), .rst_n_i(rst_n_i), .addr(bus.addr),
		.wdata(bus.wdata), .rd(bus.rd), .wr(bus.wr), .rdata(bus.rdata),
		.rdata_oe(bus.rdata_oe), .irq(bus.irq), .drq(bus.drq));

	// free-running controller clock
	always #12.5 clk_i = ~clk_i;

	// step pulses are counted so a seek is judged by distance, not time
	always @(posedge clk_i) begin
		if (step)
			step_pulses <= step_pulses + 1;
	end

	task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
		total_checks++;
		if (seen !== exp) begin
			failures++;
			$display("[ERR] %0t seen %h expected %h", $time, seen, exp);
		end
	endtask

	// one request through the host end; bounded waits catch a dead bus
	task automatic xfer(input fdc_pkg::req_kind_t k, input logic [2:0] a,
		input logic [7:0] d);
		int n;
		n = 0;
		@(posedge clk_i);
		req_valid <= 1'b1;
		req_kind <= k;
		req_addr <= a;
		req_wdata <= d;
		do begin
			@(posedge clk_i);
			n++;
		end while (req_ready !== 1'b1 && n < 50);
		req_valid <= 1'b0;
		do begin
			@(posedge clk_i);
			n++;
		end while (resp_valid !== 1'b1 && n < 400);
		q = resp_data;
		chk({7'h00, resp_valid}, 8'h01);
	endtask
	task automatic wr(input logic [2:0] a, input logic [7:0] d);
		xfer(fdc_pkg::K_REG_WR, a, d);
	endtask
	task automatic rd(input logic [2:0] a);
		xfer(fdc_pkg::K_REG_RD, a, 8'h00);
	endtask
	task automatic dw(input logic [7:0] d);
		xfer(fdc_pkg::K_DATA_WR, 3'h5, d);
	endtask
	task automatic dr();
		xfer(fdc_pkg::K_DATA_RD, 3'h5, 8'h00);
	endtask
	task automatic idle(input int n);
		repeat (n) @(posedge clk_i);
	endtask

	task automatic t_doc();
		chk({7'h00, core_reset}, 8'h01);
		wr(3'h2, 8'h2D);
		chk({5'h00, motor_en, drive_choice}, 8'h05);
		chk({7'h00, core_reset}, 8'h00);
		wr(3'h7, 8'h02);
		wr(3'h2, 8'h28);
		chk({7'h00, core_reset}, 8'h01);
		chk({6'h00, rate_sel}, 8'h02);
		rd(3'h2);
		chk(q, 8'h28);
		rd(3'h4);
		chk(q & 8'hDF, 8'h00);
		wr(3'h7, 8'h80);
		chk({7'h00, core_reset}, 8'h01);
		wr(3'h2, 8'h0C);
		chk({6'h00, core_reset, drive_choice}, 8'h00);
	endtask

	task automatic t_rate();
		for (int r = 0; r < 4; r++) begin
			wr(3'h7, 8'(r));
			chk({5'h00, reduce_write, rate_sel}, {5'h00, r != 0, 2'(r)});
		end
		wr(3'h7, 8'h81);
		rd(3'h4);
		chk(q, 8'h80);
		chk({6'h00, rate_sel}, 8'h01);
	endtask

	task automatic t_dir();
		chg_n <= 1'b0;
		idle(4);
		rd(3'h7);
		chk(q & 8'h80, 8'h80);
		chg_n <= 1'b1;
		idle(4);
		rd(3'h7);
		chk(q & 8'h80, 8'h00);
	endtask

	task automatic t_invalid();
		dw(8'h00);
		idle(4);
		chk({7'h00, irq_host}, 8'h01);
		rd(3'h4);
		chk(q, 8'hD0);
		dr();
		chk(q, 8'h80);
		rd(3'h4);
		chk(q, 8'h80);
		chk({7'h00, irq_host}, 8'h00);
	endtask

	// non-dma mode shows in status and blocks the dma request
	task automatic t_specify();
		dma_req <= 1'b1;
		dw(8'h03);
		dw(8'hAF);
		dw(8'h03);
		rd(3'h4);
		chk(q, 8'hA0);
		chk({7'h00, bus.drq}, 8'h00);
		dw(8'h03);
		dw(8'hAF);
		dw(8'h02);
		rd(3'h4);
		chk(q, 8'h80);
		chk({7'h00, bus.drq}, 8'h01);
		wr(3'h2, 8'h04);
		chk({7'h00, bus.drq}, 8'h00);
		wr(3'h2, 8'h0C);
		dma_req <= 1'b0;
	endtask

	task automatic t_seek();
		dw(8'h0F);
		dw(8'h00);
		dw(8'h03);
		rd(3'h4);
		chk(q & 8'h13, 8'h11);
		idle(120);
		chk({6'h00, step_dir, irq_host}, 8'h03);
		chk(8'(step_pulses), 8'h03);
		dw(8'h08);
		dr();
		chk(q, 8'h21);
		dr();
		chk(q, 8'h03);
	endtask

	// track zero never seen: recalibrate must give up with a check
	task automatic t_recal();
		dw(8'h07);
		dw(8'h01);
		rd(3'h4);
		chk(q & 8'h13, 8'h12);
		idle(79 * STEPS + 60);
		dw(8'h08);
		dr();
		chk(q, 8'h72);
		chk(8'(step_pulses), 8'h52);
		dr();
	endtask

	task automatic t_sense();
		fault <= 1'b1;
		wp <= 1'b1;
		two <= 1'b1;
		trk0_n <= 1'b0;
		idle(4);
		dw(8'h04);
		dw(8'h05);
		dr();
		chk(q, 8'hFD);
		chk({7'h00, side_sel}, 8'h01);
		fault <= 1'b0;
		rdy <= 1'b0;
	endtask

	// fixed-zero status bits are pulsed to prove they stay clear
	task automatic t_read_id();
		logic [7:0] exp [7];
		exp = '{8'h49, 8'h24, 8'h08, 8'h03, 8'h00, 8'h01, 8'h02};
		dw(8'h0A);
		ev1 <= 8'h6C;
		ev2 <= 8'h88;
		@(posedge clk_i);
		ev1 <= 8'h00;
		ev2 <= 8'h00;
		dw(8'h00);
		for (int i = 0; i < 7; i++) begin
			dr();
			chk(q, exp[i]);
		end
	endtask

	task automatic stop_test();
		if (failures == 0 && total_checks > 0) begin
			$display("[ PASS ]");
		end else begin
			$display("[ FAIL ]");
		end
		$finish;
	endtask

	// main sequence after six reset cycles
	initial begin
		repeat (6) @(posedge clk_i);
		rst_n_i <= 1'b1;
		t_doc();
		t_rate();
		t_dir();
		t_invalid();
		t_specify();
		t_seek();
		t_recal();
		t_sense();
		t_read_id();
		stop_test();
	end

	// watchdog: the whole run needs well under 20000 cycles
	initial begin
		#(20000 * 25);
		failures++;
		stop_test();
	end
endmodule
`default_nettype wire
